/* verilog/cfu_regs.svh */
// Function
// - enciphered binary update is class 04, instruction D6
// - decrypt with key number from low nibble of file parameter byte 15
// - length byte lies in 8..232 and equals bytes written
// - write offset is P1 high byte, P2 low byte, zero based
// - success after decrypt and store returns 9000
// - invalidated selected file refuses write with 6283
// - too long enciphered input returns 6700
// - missing key or key file gives 6981, unverified key gives 6982
// - key algorithm not authorised for decryption returns 6985
// - directory selected gives 6986, record file selected gives 6A80
// - offset beyond file bounds gives 6B00 and nothing is written
// - unknown instruction 6D00, bad class 6E00, technical fault 6F00
// - usb transport length mismatch returns 6C and expected length
// - memory write failure returns 6581
// - write allowed only once the file access condition is met
// - record update is class C0, instruction DC, P1 record, P2 mode
// - cyclic mode 02 overwrites oldest record and points at it
// - linear mode 04 updates the record numbered in P1
// - linear mode 00 picks first, 01 last, then next or previous
// - with no record selected, next gives first, previous gives last
// - missing record or no next record returns 6A83
`ifndef CFU_REGS_SVH
`define CFU_REGS_SVH
`define CFU_CLA_ENC      8'h04
`define CFU_CLA_REC      8'hC0
`define CFU_INS_ENC      8'hD6
`define CFU_INS_REC      8'hDC
`define CFU_LC_MIN       8'h08
`define CFU_LC_MAX       8'hE8
`define CFU_BLK_MASK     8'h07
`define CFU_MODE_FIRST   8'h00
`define CFU_MODE_LAST    8'h01
`define CFU_MODE_NEXT    8'h02
`define CFU_MODE_PREV    8'h03
`define CFU_MODE_ABS     8'h04
`define CFU_SW_OK        16'h9000
`define CFU_SW_INVAL     16'h6283
`define CFU_SW_MEM       16'h6581
`define CFU_SW_LEN       16'h6700
`define CFU_SW_LEN_HI    8'h67
`define CFU_SW_USB_HI    8'h6C
`define CFU_SW_NOKEY     16'h6981
`define CFU_SW_NOAUTH    16'h6982
`define CFU_SW_ALGO      16'h6985
`define CFU_SW_DF        16'h6986
`define CFU_SW_WRONGEF   16'h6A80
`define CFU_SW_NOREC     16'h6A83
`define CFU_SW_P1P2      16'h6B00
`define CFU_SW_INS       16'h6D00
`define CFU_SW_CLA       16'h6E00
`define CFU_SW_TECH      16'h6F00
`define CFU_NO_REC       8'h00
`define CFU_ONE          8'h01
`endif

/* verilog/cfu_pkg.sv */
package cfu_pkg;
  typedef enum logic [1:0] {
    CFU_FT_DF     = 2'b00,
    CFU_FT_TRANS  = 2'b01,
    CFU_FT_LINEAR = 2'b10,
    CFU_FT_CYCLIC = 2'b11
  } cfu_ftype_type;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
  } cfu_hdr_type;

  typedef struct packed {
    cfu_ftype_type ftype;
    logic          invalid;
    logic [15:0]   size;
    logic [7:0]    rec_len;
    logic [7:0]    rec_count;
    logic [7:0]    param15;
    logic          ac_ok;
    logic          key_file;
    logic          key_present;
    logic          key_valid;
    logic          algo_ok;
  } cfu_file_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } cfu_wr_type;
endpackage

/* verilog/cfu_blk_count.sv */
`timescale 1ns/10ps
`include "cfu_regs.svh"
// counts input bytes and flags each completed eight-byte block
module cfu_blk_count
  import cfu_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic clear,
  input  wire logic step,
  output logic      block_done
);
  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_block_done;

  always_comb begin
    next_count      = count;
    next_block_done = 1'b0;
    if (clear) begin
      next_count = 3'h0;
    end else if (step) begin
      next_count      = count + 3'h1;
      next_block_done = (count == 3'h7);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count      <= 3'h0;
      block_done <= 1'b0;
    end else begin
      count      <= next_count;
      block_done <= next_block_done;
    end
  end
endmodule

/* verilog/cfu_rec_sel.sv */
`timescale 1ns/10ps
`include "cfu_regs.svh"
// picks the target record number from mode, P1 and the record pointer
module cfu_rec_sel
  import cfu_pkg::*;
(
  input  wire cfu_ftype_type ftype,
  input  wire logic [7:0]    mode,
  input  wire logic [7:0]    p1,
  input  wire logic [7:0]    pointer,
  input  wire logic [7:0]    oldest,
  input  wire logic [7:0]    rec_count,
  output logic [7:0]         target,
  output logic [15:0]        fault
);
  always_comb begin
    target = `CFU_NO_REC;
    fault  = 16'h0000;
    if (ftype == CFU_FT_CYCLIC) begin
      if (mode == `CFU_MODE_NEXT && p1 == `CFU_NO_REC) begin
        target = oldest;
      end else begin
        fault = `CFU_SW_P1P2;
      end
    end else begin
      case (mode)
        `CFU_MODE_FIRST: target = `CFU_ONE;
        `CFU_MODE_LAST:  target = rec_count;
        `CFU_MODE_NEXT: begin
          if (pointer == `CFU_NO_REC) begin
            target = `CFU_ONE;
          end else if (pointer >= rec_count) begin
            fault = `CFU_SW_NOREC;
          end else begin
            target = pointer + `CFU_ONE;
          end
        end
        `CFU_MODE_PREV: begin
          if (pointer == `CFU_NO_REC) begin
            target = rec_count;
          end else if (pointer == `CFU_ONE) begin
            fault = `CFU_SW_NOREC;
          end else begin
            target = pointer - `CFU_ONE;
          end
        end
        `CFU_MODE_ABS: target = (p1 == `CFU_NO_REC) ? pointer : p1;
        default: fault = `CFU_SW_P1P2;
      endcase
      if (fault == 16'h0000 &&
          (target == `CFU_NO_REC || target > rec_count)) begin
        fault = `CFU_SW_NOREC;
      end
    end
  end
endmodule

/* verilog/cfu_update_cmds.sv */
`timescale 1ns/10ps
`include "cfu_regs.svh"
// ****************************************************************
// command interpreter for enciphered binary and record updates
// ****************************************************************
module cfu_update_cmds
  import cfu_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          cmd_valid,
  input  wire cfu_hdr_type   cmd_hdr,
  input  wire cfu_file_type  file,
  input  wire logic          usb_mode,
  input  wire logic [7:0]    usb_len,
  input  wire logic          data_valid,
  input  wire logic [7:0]    data_byte,
  output logic               data_ready,
  output logic [3:0]         key_number,
  output logic               des_start,
  output logic [63:0]        des_block,
  input  wire logic          des_done,
  input  wire logic [63:0]   des_plain,
  output cfu_wr_type         nvm_wr,
  input  wire logic          nvm_ack,
  input  wire logic          nvm_fail,
  output logic [7:0]         record_pointer,
  output logic [7:0]         record_oldest,
  output logic               sw_valid,
  output logic [15:0]        sw
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    CFU_IDLE   = 3'b000,
    CFU_RECV   = 3'b001,
    CFU_DECR   = 3'b010,
    CFU_WRITE  = 3'b011,
    CFU_DONE   = 3'b100
  } cfu_state_type;

  cfu_state_type state, next_state;
  cfu_hdr_type   hdr, next_hdr;
  logic [63:0]   buf_q, next_buf_q;
  logic [15:0]   addr, next_addr;
  logic [7:0]    left, next_left;
  logic [7:0]    recv_left, next_recv_left;
  logic [3:0]    widx, next_widx;
  logic          is_rec, next_is_rec;
  logic [7:0]    target_q, next_target_q;
  logic [7:0]    next_record_pointer, next_record_oldest;
  logic          next_data_ready, next_des_start, next_sw_valid;
  logic [63:0]   next_des_block;
  logic [3:0]    next_key_number;
  cfu_wr_type    next_nvm_wr;
  logic [15:0]   next_sw;
  logic          block_done;
  logic          cnt_clear;
  logic [7:0]    sel_target;
  logic [15:0]   sel_fault;

  cfu_blk_count u_blk (
    .clock      (clock),
    .resetn     (resetn),
    .clear      (cnt_clear),
    .step       (data_valid && data_ready),
    .block_done (block_done)
  );

  cfu_rec_sel u_sel (
    .ftype     (file.ftype),
    .mode      (cmd_hdr.p2),
    .p1        (cmd_hdr.p1),
    .pointer   (record_pointer),
    .oldest    (record_oldest),
    .rec_count (file.rec_count),
    .target    (sel_target),
    .fault     (sel_fault)
  );

  // access checks shared by both commands
  function automatic logic [15:0] cfu_access(input cfu_file_type f);
    if (!f.key_file || !f.key_present) cfu_access = `CFU_SW_NOKEY;
    else if (!f.key_valid || !f.ac_ok) cfu_access = `CFU_SW_NOAUTH;
    else cfu_access = 16'h0000;
  endfunction

  // ****************************************************************
  // header screening, checks in priority order
  // ****************************************************************
  function automatic logic [15:0] cfu_screen(
    input cfu_hdr_type h, input cfu_file_type f,
    input logic usb, input logic [7:0] ulen,
    input logic [15:0] rfault);
    logic [16:0] end_addr;
    logic        enc;
    end_addr = {1'b0, h.p1, h.p2} + {9'h000, h.lc};
    enc      = (h.ins == `CFU_INS_ENC);
    cfu_screen = 16'h0000;
    if (h.ins != `CFU_INS_ENC && h.ins != `CFU_INS_REC)
      cfu_screen = `CFU_SW_INS;
    else if (enc ? (h.cla != `CFU_CLA_ENC) : (h.cla != `CFU_CLA_REC))
      cfu_screen = `CFU_SW_CLA;
    else if (usb && ulen != h.lc)
      cfu_screen = {`CFU_SW_USB_HI, h.lc};
    else if (f.ftype == CFU_FT_DF)
      cfu_screen = `CFU_SW_DF;
    else if (enc ? (f.ftype != CFU_FT_TRANS) : (f.ftype == CFU_FT_TRANS))
      cfu_screen = `CFU_SW_WRONGEF;
    else if (f.invalid)
      cfu_screen = `CFU_SW_INVAL;
    else if (cfu_access(f) != 16'h0000)
      cfu_screen = cfu_access(f);
    else if (enc && !f.algo_ok)
      cfu_screen = `CFU_SW_ALGO;
    else if (enc && h.lc > `CFU_LC_MAX)
      cfu_screen = `CFU_SW_LEN;
    else if (enc && (h.lc < `CFU_LC_MIN ||
                     (h.lc & `CFU_BLK_MASK) != 8'h00))
      cfu_screen = `CFU_SW_LEN;
    else if (enc && ({h.p1, h.p2} >= f.size || end_addr > {1'b0, f.size}))
      cfu_screen = `CFU_SW_P1P2;
    else if (!enc && rfault != 16'h0000)
      cfu_screen = rfault;
    else if (!enc && h.lc != f.rec_len)
      cfu_screen = {`CFU_SW_LEN_HI, f.rec_len};
  endfunction

  assign cnt_clear = (state == CFU_IDLE);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [15:0] chk;
    chk                 = 16'h0000;
    next_state          = state;
    next_hdr            = hdr;
    next_buf_q          = buf_q;
    next_addr           = addr;
    next_left           = left;
    next_recv_left      = recv_left;
    next_widx           = widx;
    next_is_rec         = is_rec;
    next_target_q       = target_q;
    next_record_pointer = record_pointer;
    next_record_oldest  = record_oldest;
    next_data_ready     = 1'b0;
    next_des_start      = 1'b0;
    next_des_block      = des_block;
    next_key_number     = key_number;
    next_nvm_wr         = '0;
    next_sw_valid       = 1'b0;
    next_sw             = sw;
    case (state)
      CFU_IDLE: begin
        if (cmd_valid) begin
          chk         = cfu_screen(cmd_hdr, file, usb_mode, usb_len,
                                   sel_fault);
          next_hdr    = cmd_hdr;
          next_is_rec = (cmd_hdr.ins == `CFU_INS_REC);
          next_key_number = file.param15[3:0];
          next_target_q   = sel_target;
          next_left       = cmd_hdr.lc;
          next_recv_left  = cmd_hdr.lc;
          next_widx       = 4'h0;
          if (cmd_hdr.ins == `CFU_INS_REC)
            next_addr = 16'((sel_target - `CFU_ONE) * file.rec_len);
          else
            next_addr = {cmd_hdr.p1, cmd_hdr.p2};
          if (chk != 16'h0000) begin
            next_sw       = chk;
            next_sw_valid = 1'b1;
          end else begin
            next_state      = CFU_RECV;
            next_data_ready = 1'b1;
          end
        end
      end
      CFU_RECV: begin
        next_data_ready = 1'b1;
        if (data_valid && data_ready) begin
          next_buf_q     = {buf_q[55:0], data_byte};
          next_recv_left = recv_left - `CFU_ONE;
          // ready drops with the byte that closes a block; block_done lags
          if (is_rec || (recv_left & `CFU_BLK_MASK) == `CFU_ONE) begin
            next_data_ready = 1'b0;
          end
        end
        if (block_done && !is_rec) begin
          next_data_ready = 1'b0;
          next_des_block  = buf_q;
          next_des_start  = 1'b1;
          next_state      = CFU_DECR;
        end else if (is_rec && !data_ready && recv_left != left) begin
          next_data_ready = 1'b0;
          next_widx       = 4'h7;
          next_state      = CFU_WRITE;
        end
      end
      CFU_DECR: begin
        if (des_done) begin
          next_buf_q = des_plain;
          next_widx  = 4'h0;
          next_state = CFU_WRITE;
        end
      end
      CFU_WRITE: begin
        if (!nvm_wr.valid || nvm_ack) begin
          // fail is only meaningful alongside the ack
          if (nvm_ack && nvm_fail) begin
            next_sw       = `CFU_SW_MEM;
            next_sw_valid = 1'b1;
            next_state    = CFU_IDLE;
          end else if (nvm_wr.valid) begin
            next_addr = addr + 16'h0001;
            next_left = left - `CFU_ONE;
            next_widx = widx + 4'h1;
            if (left == `CFU_ONE) begin
              next_state = CFU_DONE;
            end else if (is_rec || widx == 4'h7) begin
              next_state      = CFU_RECV;
              next_data_ready = 1'b1;
            end
          end else begin
            next_nvm_wr.valid = 1'b1;
            next_nvm_wr.addr  = addr;
            next_nvm_wr.data  = buf_q[8*(7-widx[2:0]) +: 8];
          end
        end else begin
          next_nvm_wr = nvm_wr;
        end
      end
      CFU_DONE: begin
        if (is_rec) begin
          if (file.ftype == CFU_FT_CYCLIC) begin
            next_record_pointer = target_q;
            next_record_oldest  = (target_q >= file.rec_count) ?
                                  `CFU_ONE : target_q + `CFU_ONE;
          end else if (hdr.p2 != `CFU_MODE_ABS) begin
            next_record_pointer = target_q;
          end
        end
        next_sw       = `CFU_SW_OK;
        next_sw_valid = 1'b1;
        next_state    = CFU_IDLE;
      end
      default: begin
        next_sw       = `CFU_SW_TECH;
        next_sw_valid = 1'b1;
        next_state    = CFU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state          <= CFU_IDLE;
      hdr            <= '0;
      buf_q          <= 64'h0;
      addr           <= 16'h0000;
      left           <= 8'h00;
      recv_left      <= 8'h00;
      widx           <= 4'h0;
      is_rec         <= 1'b0;
      target_q       <= 8'h00;
      record_pointer <= `CFU_NO_REC;
      record_oldest  <= `CFU_ONE;
      data_ready     <= 1'b0;
      des_start      <= 1'b0;
      des_block      <= 64'h0;
      key_number     <= 4'h0;
      nvm_wr         <= '0;
      sw_valid       <= 1'b0;
      sw             <= 16'h0000;
    end else begin
      state          <= next_state;
      hdr            <= next_hdr;
      buf_q          <= next_buf_q;
      addr           <= next_addr;
      left           <= next_left;
      recv_left      <= next_recv_left;
      widx           <= next_widx;
      is_rec         <= next_is_rec;
      target_q       <= next_target_q;
      record_pointer <= next_record_pointer;
      record_oldest  <= next_record_oldest;
      data_ready     <= next_data_ready;
      des_start      <= next_des_start;
      des_block      <= next_des_block;
      key_number     <= next_key_number;
      nvm_wr         <= next_nvm_wr;
      sw_valid       <= next_sw_valid;
      sw             <= next_sw;
    end
  end
endmodule

/* verif/cfu_update_cmds_monitor.sv */
`timescale 1ns/10ps
`include "cfu_regs.svh"
// ****************************************
// status and write checks at the ports
// ****************************************
module cfu_update_cmds_monitor
  import cfu_pkg::*;
(
  input wire logic         clock,
  input wire logic         resetn,
  input wire logic         cmd_valid,
  input wire cfu_hdr_type  cmd_hdr,
  input wire cfu_file_type file,
  input wire logic         usb_mode,
  input wire logic [3:0]   key_number,
  input wire logic         des_start,
  input wire cfu_wr_type   nvm_wr,
  input wire logic         nvm_ack,
  input wire logic         nvm_fail,
  input wire logic         sw_valid,
  input wire logic [15:0]  sw
);
  logic busy;
  logic next_busy;
  logic take;
  logic enc;
  // busy mirrors the one-command-at-a-time order
  assign take = cmd_valid && !busy;
  assign enc  = cmd_hdr.cla == `CFU_CLA_ENC && cmd_hdr.ins == `CFU_INS_ENC
                && !usb_mode;
  always_comb begin
    next_busy = busy;
    if (take)
      next_busy = 1'b1;
    else if (sw_valid)
      next_busy = 1'b0;
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      busy <= 1'b0;
    else
      busy <= next_busy;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_enc_take;
    take && enc;
  endsequence
  sequence s_trans_ok;
    file.ftype == CFU_FT_TRANS && !file.invalid;
  endsequence
  chk_bad_ins: assert property (
    take && cmd_hdr.ins != `CFU_INS_ENC && cmd_hdr.ins != `CFU_INS_REC
    |=> sw_valid && sw == `CFU_SW_INS) else $error("bad ins status");
  chk_bad_class: assert property (
    take && ((cmd_hdr.ins == `CFU_INS_ENC && cmd_hdr.cla != `CFU_CLA_ENC)
    || (cmd_hdr.ins == `CFU_INS_REC && cmd_hdr.cla != `CFU_CLA_REC))
    |=> sw_valid && sw == `CFU_SW_CLA) else $error("bad class status");
  chk_dir_refused: assert property (
    s_enc_take ##0 file.ftype == CFU_FT_DF
    |=> sw_valid && sw == `CFU_SW_DF) else $error("dir status");
  chk_invalid_ef: assert property (
    s_enc_take ##0 (file.ftype == CFU_FT_TRANS && file.invalid)
    |=> sw_valid && sw == `CFU_SW_INVAL) else $error("invalid status");
  chk_key_absent: assert property (
    s_enc_take ##0 s_trans_ok ##0 !file.key_file
    |=> sw_valid && sw == `CFU_SW_NOKEY) else $error("no key status");
  chk_key_nibble: assert property (
    des_start |-> key_number == file.param15[3:0])
    else $error("wrong key number");
  chk_write_gated: assert property (
    nvm_wr.valid |-> file.ac_ok && !sw_valid) else $error("ungated write");
  chk_mem_fail: assert property (
    nvm_ack && nvm_fail |-> ##[1:4] (sw_valid && sw == `CFU_SW_MEM))
    else $error("memory fail status");
endmodule
bind cfu_update_cmds cfu_update_cmds_monitor cfu_update_cmds_monitor_i (
  .clock, .resetn, .cmd_valid, .cmd_hdr, .file, .usb_mode, .key_number,
  .des_start, .nvm_wr, .nvm_ack, .nvm_fail, .sw_valid, .sw);

/* verif/cfu_partner.sv */
`timescale 1ns/10ps
// ****************************************
// cipher engine and memory stand-in
// ****************************************
module cfu_partner
  import cfu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        des_start,
  input  wire logic [63:0] des_block,
  input  wire cfu_wr_type  nvm_wr,
  input  wire logic        fail_en,
  input  wire logic        slow,
  output logic             des_done,
  output logic [63:0]      des_plain,
  output logic             nvm_ack,
  output logic             nvm_fail
);
  localparam logic [63:0] KEY = 64'h5A5A5A5A5A5A5A5A;
  logic [7:0]  mem [0:255];
  logic [15:0] wr_count;
  logic [15:0] last_addr;
  logic [1:0]  cnt;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      des_done  <= 1'b0;
      des_plain <= 64'h0;
      nvm_ack   <= 1'b0;
      nvm_fail  <= 1'b0;
      cnt       <= 2'h0;
      wr_count  <= 16'h0;
      last_addr <= 16'h0;
    end else begin
      des_done  <= des_start;
      // plain text churns when not fresh, so stale reads show up
      des_plain <= des_start ? des_block ^ KEY : ~des_plain;
      nvm_ack   <= 1'b0;
      nvm_fail  <= ~nvm_fail;
      if (nvm_wr.valid && !nvm_ack) begin
        if (cnt == (slow ? 2'h3 : 2'h0)) begin
          nvm_ack   <= 1'b1;
          nvm_fail  <= fail_en;
          cnt       <= 2'h0;
          wr_count  <= wr_count + 16'h1;
          last_addr <= nvm_wr.addr;
          if (!fail_en)
            mem[nvm_wr.addr[7:0]] <= nvm_wr.data;
        end else
          cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

/* verif/cfu_update_cmds_tb.sv */
`timescale 1ns/10ps
`include "cfu_regs.svh"
// ****************************************
// command-level scenarios
// ****************************************
module cfu_update_cmds_tb
  import cfu_pkg::*;
();
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  logic         cmd_valid = 1'b0;
  logic         usb_mode = 1'b0;
  logic         data_valid = 1'b0;
  logic         fail_en = 1'b0;
  logic         slow = 1'b0;
  logic [7:0]   data_byte = 8'h00;
  logic [7:0]   st = 8'h00;
  logic [7:0]   usb_len = 8'h00;
  logic         des_done, nvm_ack, nvm_fail, data_ready, des_start, sw_valid;
  logic [3:0]   key_number;
  logic [63:0]  des_block, des_plain;
  logic [7:0]   record_pointer, record_oldest;
  logic [15:0]  sw, sw_got;
  cfu_hdr_type  cmd_hdr = '0;
  cfu_wr_type   nvm_wr;
  cfu_file_type file = '{CFU_FT_TRANS, 1'b0, 16'h0148, 8'h02, 8'h03,
                         8'h37, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  int           fail_count = 0;
  int           samples_checked = 0;
  localparam logic [15:0] ERR [16] = '{`CFU_SW_INS, `CFU_SW_CLA, 16'h6C08,
    `CFU_SW_DF, `CFU_SW_WRONGEF, `CFU_SW_INVAL, `CFU_SW_NOKEY,
    `CFU_SW_NOAUTH, `CFU_SW_NOAUTH, `CFU_SW_ALGO, `CFU_SW_LEN, `CFU_SW_LEN,
    `CFU_SW_P1P2, `CFU_SW_CLA, `CFU_SW_NOKEY, `CFU_SW_WRONGEF};
  always #2 clock = ~clock;
  cfu_update_cmds cfu_update_cmds_i (.clock, .resetn, .cmd_valid, .cmd_hdr,
    .file, .usb_mode, .usb_len, .data_valid, .data_byte, .data_ready,
    .key_number, .des_start, .des_block, .des_done, .des_plain, .nvm_wr,
    .nvm_ack, .nvm_fail, .record_pointer, .record_oldest, .sw_valid, .sw);
  cfu_partner cfu_partner_i (.clock, .resetn, .des_start, .des_block,
    .nvm_wr, .fail_en, .slow, .des_done, .des_plain, .nvm_ack, .nvm_fail);
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bytes move only on a ready seen at the rising edge
  task automatic run(input logic [7:0] c, i, a, b, l, n, d);
    int k;
    int t;
    logic acc;
    k = 0;
    t = 0;
    @(negedge clock);
    cmd_hdr = '{c, i, a, b, l};
    cmd_valid = 1'b1;
    data_valid = (n != 8'h00);
    data_byte = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (sw_valid !== 1'b1) begin
      @(posedge clock);
      acc = data_valid && data_ready;
      @(negedge clock);
      if (acc)
        k++;
      data_valid = (k < n);
      data_byte = d + k[7:0];
      t++;
      if (t > 3000) begin
        fail_count++;
        $display("CHECK FAILED %0t no status", $time);
        end_sim();
      end
    end
    sw_got = sw;
    data_valid = 1'b0;
  endtask
  task automatic t_enc_ok();
    run(8'h04, 8'hD6, 8'h01, 8'h38, 8'h10, 8'h10, 8'h30);
    check(sw_got, `CFU_SW_OK);
    check(cfu_partner_i.last_addr, 16'h0147);
    for (int j = 0; j < 16; j++)
      check(cfu_partner_i.mem[8'h38 + j],
            (8'h30 + j) ^ 8'h5A);
  endtask
  // usb transfer with matching length must pass the length screen
  task automatic t_enc_fail();
    fail_en = 1'b1;
    usb_mode = 1'b1;
    usb_len = 8'h08;
    run(8'h04, 8'hD6, 8'h00, 8'h00, 8'h08, 8'h08, 8'h11);
    check(sw_got, `CFU_SW_MEM);
    fail_en = 1'b0;
    usb_mode = 1'b0;
    usb_len = 8'h00;
  endtask
  task automatic t_errors();
    cfu_file_type g;
    logic [15:0] w;
    logic [7:0] c, i, b, l;
    g = file;
    for (int k = 0; k < 16; k++) begin
      c = 8'h04;
      i = 8'hD6;
      b = 8'h38;
      l = 8'h08;
      w = cfu_partner_i.wr_count;
      case (k)
        0: i = 8'hA4;
        1: c = 8'hC0;
        2: usb_mode = 1'b1;
        3: file.ftype = CFU_FT_DF;
        4: file.ftype = CFU_FT_LINEAR;
        5: file.invalid = 1'b1;
        6: file.key_file = 1'b0;
        7: file.key_valid = 1'b0;
        8: file.ac_ok = 1'b0;
        9: file.algo_ok = 1'b0;
        10: l = 8'hF0;
        11: l = 8'h0C;
        12: b = 8'h48;
        13: i = 8'hDC;
        14: file.key_present = 1'b0;
        default: begin
          c = 8'hC0;
          i = 8'hDC;
        end
      endcase
      run(c, i, 8'h01, b, l, 8'h00, 8'h00);
      check(sw_got, ERR[k]);
      check(cfu_partner_i.wr_count, w);
      file = g;
      usb_mode = 1'b0;
    end
  endtask
  task automatic rec(input logic [7:0] a, b, t, p, o, input logic [15:0] e);
    st++;
    run(8'hC0, 8'hDC, a, b, 8'h02, 8'h02, {st[3:0], 4'h0});
    check(sw_got, e);
    check(record_pointer, p);
    check(record_oldest, o);
    if (e === `CFU_SW_OK) begin
      check(cfu_partner_i.mem[t * 2 - 2], {st[3:0], 4'h0});
      check(cfu_partner_i.mem[t * 2 - 1], {st[3:0], 4'h1});
    end
  endtask
  task automatic t_rec_linear();
    file.ftype = CFU_FT_LINEAR;
    file.size = 16'h0006;
    rec(8'h00, 8'h03, 8'h03, 8'h03, 8'h01, `CFU_SW_OK);
    rec(8'h00, 8'h02, 8'h00, 8'h03, 8'h01, `CFU_SW_NOREC);
    rec(8'h00, 8'h00, 8'h01, 8'h01, 8'h01, `CFU_SW_OK);
    rec(8'h00, 8'h02, 8'h02, 8'h02, 8'h01, `CFU_SW_OK);
    rec(8'h00, 8'h03, 8'h01, 8'h01, 8'h01, `CFU_SW_OK);
    rec(8'h03, 8'h04, 8'h03, 8'h01, 8'h01, `CFU_SW_OK);
    rec(8'h04, 8'h04, 8'h00, 8'h01, 8'h01, `CFU_SW_NOREC);
    rec(8'h00, 8'h03, 8'h00, 8'h01, 8'h01, `CFU_SW_NOREC);
    rec(8'h00, 8'h04, 8'h01, 8'h01, 8'h01, `CFU_SW_OK);
    rec(8'h00, 8'h01, 8'h03, 8'h03, 8'h01, `CFU_SW_OK);
  endtask
  // slow memory here, so the write handshake is stretched
  task automatic t_rec_cyclic();
    slow = 1'b1;
    file.ftype = CFU_FT_CYCLIC;
    file.rec_count = 8'h02;
    file.size = 16'h0004;
    rec(8'h00, 8'h02, 8'h01, 8'h01, 8'h02, `CFU_SW_OK);
    rec(8'h00, 8'h02, 8'h02, 8'h02, 8'h01, `CFU_SW_OK);
    rec(8'h00, 8'h02, 8'h01, 8'h01, 8'h02, `CFU_SW_OK);
    rec(8'h00, 8'h00, 8'h00, 8'h01, 8'h02, `CFU_SW_P1P2);
  endtask
  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    t_enc_ok();
    t_enc_fail();
    t_errors();
    t_rec_linear();
    t_rec_cyclic();
    end_sim();
  end
endmodule
